// *** rtl/rsu_pkg.sv ***
// constants, field layouts and types of the remote upgrade controller
// assumes one 250 MHz clock; the 10 MHz oscillator is a tick derived from it
//
// How it works
// RULE1 - factory image loads update register with app flag, page, watchdog first
// RULE2 - fabric request release in factory copies update into control, reconfigures
// RULE3 - error or trigger events set control per mode and cause table
// RULE4 - local mode external reset or fabric trigger gives page one, flag one
// RULE5 - status register records cause before the next image loads
// RULE6 - watchdog counts down in 29 bits, upper 12 bits programmable
// RULE7 - watchdog advances on the oscillator tick, not the shift clock
// RULE8 - watchdog off while configuring and in factory images
// RULE9 - application logic restarts watchdog before expiry
// RULE10 - falling edge on watchdog restart reloads the initial count
// RULE11 - watchdog expiry sets timeout cause and loads factory image
// RULE12 - watchdog restart works only for application images in remote mode
// RULE13 - other fabric signals work in every mode and image
// RULE14 - fabric request reconfigures: factory to app, app to factory, local to app
// RULE15 - shift clock drives shift and update registers, sampled on rise
// RULE16 - shift select high shifts left each shift-clock rise, capture ignored
// RULE17 - capture loads status plus control in app, update in factory
// RULE18 - both selects low copy shift into update, factory remote only
// RULE19 - in local mode a low capture select does nothing
// RULE20 - serial input shifts in on shift-clock rises while shift high
// RULE21 - serial output shows next shift bit after each shift-clock rise
// RULE22 - control layout: flag bit 0, page 1..7, enable 8, count 9..20
// RULE23 - control and status on oscillator side, shift and update on shift clock; here control and status change on any rising aclk edge
// RULE24 - status holds five cause flags, zero at power-on
// RULE25 - power-up page is zero in remote mode, one in local mode
// RULE26 - capture fills shift register with status then 21 register bits
package rsu_pkg;

  // ==========================================================
  // register widths and field positions
  localparam int CTRL_W    = 21;
  localparam int STAT_W    = 5;
  localparam int SHIFT_W   = 26;
  localparam int WD_W      = 29;
  localparam int WD_UP_W   = 12;
  localparam int WD_LOW_W  = WD_W - WD_UP_W;
  localparam int ANF_BIT   = 0;  // see RULE22
  localparam int PAGE_LSB  = 1;
  localparam int PAGE_W    = 7;
  localparam int WDEN_BIT  = 8;
  localparam int WDUP_LSB  = 9;

  // status cause bits
  localparam int ST_CHECKSUM = 0;
  localparam int ST_STATUS   = 1;
  localparam int ST_FABRIC   = 2;
  localparam int ST_EXTRST   = 3;
  localparam int ST_WDOG     = 4;

  // ==========================================================
  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST_REMOTE = 21'h000000;
  localparam logic [CTRL_W-1:0] CTRL_LOCAL_APP  = 21'h000003;
  localparam logic [STAT_W-1:0] STAT_RST        = 5'h00;
  localparam logic              REMOTE_RST      = 1'b1;

  // ==========================================================
  // bus register byte offsets
  localparam logic [7:0] OFS_MODE    = 8'h00;
  localparam logic [7:0] OFS_CMD     = 8'h04;
  localparam logic [7:0] OFS_CONTROL = 8'h08;
  localparam logic [7:0] OFS_UPDATE  = 8'h0c;
  localparam logic [7:0] OFS_STATUS  = 8'h10;
  localparam logic [7:0] OFS_WDOG    = 8'h14;
  localparam int CMD_CFG_DONE = 0;
  localparam int CMD_CHECKSUM = 1;
  localparam int CMD_EXTRST   = 2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // timing: oscillator tick derived from the bus clock
  localparam int CLK_PERIOD_NS = 4;
  localparam int OSC_PERIOD_NS = 100;
  localparam int OSC_DIV       = OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int OSC_CNT_W     = 5;

  typedef enum logic [0:0] {
    RSU_CONFIG = 1'b0,
    RSU_USER   = 1'b1
  } rsu_state_t;

endpackage

// *** rtl/rsu_pin_sync.sv ***
// three-stage pin synchroniser with agreement filter and edge pulses
// assumes pins are asynchronous to aclk and change slower than 3 cycles
`timescale 1ns/1ns
module rsu_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] level_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
  } rsu_sync_t;

  rsu_sync_t r_q;
  rsu_sync_t r_d;

  // level changes only when the second and third stage agree
  always_comb begin
    r_d      = r_q;
    r_d.s1   = pin_i;
    r_d.s2   = r_q.s1;
    r_d.s3   = r_q.s2;
    r_d.rise = '0;
    r_d.fall = '0;
    for (int i = 0; i < W; i++) begin
      if (r_q.s2[i] == r_q.s3[i] && r_q.s3[i] != r_q.lvl[i]) begin
        r_d.lvl[i]  = r_q.s3[i];
        r_d.rise[i] = r_q.s3[i];
        r_d.fall[i] = ~r_q.s3[i];
      end
    end
  end

  // the active-low request inputs idle high, so reset to ones avoids false falls
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_q      <= '0;
      r_q.s1   <= '1;
      r_q.s2   <= '1;
      r_q.s3   <= '1;
      r_q.lvl  <= '1;
    end else begin
      r_q <= r_d;
    end
  end

  assign level_o = r_q.lvl;
  assign rise_o  = r_q.rise;
  assign fall_o  = r_q.fall;
endmodule

// *** rtl/rsu_ctrl.sv ***
// remote upgrade controller: control/update/status registers, shift port,
// user watchdog and an AXI4-Lite view of the same state
// assumes fabric pins are asynchronous and slow against aclk
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
module rsu_ctrl
  import rsu_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        upgrade_shift_clock,
  input  wire logic        shift_not_load_select,
  input  wire logic        capture_not_update_select,
  input  wire logic        upgrade_serial_in,
  output logic             upgrade_serial_out,
  input  wire logic        fabric_reconfig_request_n,
  input  wire logic        watchdog_restart_n,
  input  wire logic        external_status_error_n,
  output logic             reconfig_start
);
  import rsu_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic                 remote;
    rsu_state_t           st;
    logic [CTRL_W-1:0]    ctrl;
    logic [CTRL_W-1:0]    upd;
    logic [STAT_W-1:0]    stat;
    logic [SHIFT_W-1:0]   sr;
    logic [WD_W-1:0]      wd;
    logic [OSC_CNT_W-1:0] osc;
    logic                 reconf;
    logic                 dout;
    logic                 awrdy;
    logic                 wrdy;
    logic [7:0]           awaddr;
    logic [31:0]          wdata;
    logic                 wen;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 arrdy;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
  } rsu_regs_t;

  rsu_regs_t r_q;
  rsu_regs_t r_d;

  // ==========================================================
  // pin synchronisers
  // bit order: 0 shift clock, 1 shift select, 2 capture select,
  // 3 serial in, 4 reconfig request, 5 watchdog restart, 6 status error
  logic [6:0] pin_lvl;
  logic [6:0] pin_rise;
  logic [6:0] pin_fall;

  rsu_pin_sync #(.W(7)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_i   ({external_status_error_n, watchdog_restart_n,
                fabric_reconfig_request_n, upgrade_serial_in,
                capture_not_update_select, shift_not_load_select,
                upgrade_shift_clock}),
    .level_o (pin_lvl),
    .rise_o  (pin_rise),
    .fall_o  (pin_fall)
  );

  // ==========================================================
  // helpers

  // initial watchdog count from the control word
  function automatic logic [WD_W-1:0] wd_load(input logic [CTRL_W-1:0] c);
    wd_load = {c[WDUP_LSB +: WD_UP_W], {WD_LOW_W{1'b0}}};  // see RULE6
  endfunction

  // control word chosen after a trigger, by mode and cause
  function automatic logic [CTRL_W-1:0] next_ctrl(
    input logic [STAT_W-1:0] cause,
    input logic              remote,
    input logic [CTRL_W-1:0] ctrl,
    input logic [CTRL_W-1:0] upd
  );
    next_ctrl = CTRL_RST_REMOTE;  // see RULE3
    if (cause[ST_EXTRST] || cause[ST_FABRIC]) begin
      if (!remote) begin
        next_ctrl = CTRL_LOCAL_APP;  // see RULE4
      end else if (cause[ST_FABRIC] && !ctrl[ANF_BIT]) begin
        next_ctrl = upd;  // see RULE2
      end
    end
    if (cause[ST_CHECKSUM] || cause[ST_STATUS] || cause[ST_WDOG]) begin
      next_ctrl = CTRL_RST_REMOTE;  // see RULE3
    end
  endfunction

  // read mux
  function automatic logic [31:0] read_word(input logic [7:0] a, input rsu_regs_t r);
    read_word = 32'h00000000;
    unique case (a)
      OFS_MODE:    read_word = {31'h00000000, r.remote};
      OFS_CMD:     read_word = {31'h00000000, r.st == RSU_USER};
      OFS_CONTROL: read_word = {11'h000, r.ctrl};
      OFS_UPDATE:  read_word = {11'h000, r.upd};
      OFS_STATUS:  read_word = {27'h0000000, r.stat};
      OFS_WDOG:    read_word = {3'h0, r.wd};
      default:     read_word = 32'h00000000;
    endcase
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == OFS_MODE) || (a == OFS_CMD) || (a == OFS_CONTROL) ||
              (a == OFS_UPDATE) || (a == OFS_STATUS) || (a == OFS_WDOG);
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    logic [STAT_W-1:0] cause;
    logic              wr_go;
    logic              app_img;
    logic              wd_run;
    logic              clk_rise;
    cause    = '0;
    wr_go    = 1'b0;
    app_img  = 1'b0;
    wd_run   = 1'b0;
    clk_rise = 1'b0;
    r_d        = r_q;
    r_d.reconf = 1'b0;
    app_img    = r_q.ctrl[ANF_BIT];

    // write channel: take address and data in either order
    if (s_axi_awvalid && r_q.awrdy) begin
      r_d.awaddr = s_axi_awaddr;
      r_d.awrdy  = 1'b0;
    end
    if (s_axi_wvalid && r_q.wrdy) begin
      r_d.wdata = s_axi_wdata;
      r_d.wen   = s_axi_wstrb[0];
      r_d.wrdy  = 1'b0;
    end
    wr_go = !r_q.awrdy && !r_q.wrdy && !r_q.bvalid;
    if (wr_go) begin
      r_d.bvalid = 1'b1;
      r_d.bresp  = addr_ok(r_q.awaddr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (r_q.bvalid && s_axi_bready) begin
      r_d.bvalid = 1'b0;
      r_d.awrdy  = 1'b1;
      r_d.wrdy   = 1'b1;
    end

    // read channel
    if (s_axi_arvalid && r_q.arrdy) begin
      r_d.arrdy  = 1'b0;
      r_d.rvalid = 1'b1;
      r_d.rdata  = read_word(s_axi_araddr, r_q);
      r_d.rresp  = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (r_q.rvalid && s_axi_rready) begin
      r_d.rvalid = 1'b0;
      r_d.arrdy  = 1'b1;
    end

    // oscillator tick divider; only the watchdog countdown moves on its tick
    if (r_q.osc == OSC_CNT_W'(OSC_DIV - 1)) begin  // see RULE23
      r_d.osc = '0;
    end else begin
      r_d.osc = r_q.osc + 1'b1;
    end

    // shift port, stepped by each filtered shift-clock rise
    clk_rise = pin_rise[0];  // see RULE15, RULE13
    if (clk_rise) begin
      if (pin_lvl[1]) begin
        r_d.sr = {r_q.sr[SHIFT_W-2:0], pin_lvl[3]};  // see RULE16, RULE20
      end else if (pin_lvl[2]) begin
        r_d.sr = {r_q.stat, app_img ? r_q.ctrl : r_q.upd};  // see RULE17, RULE26
      end else if (r_q.remote && !app_img) begin
        r_d.upd = r_q.sr[CTRL_W-1:0];  // see RULE18, RULE19
      end
    end
    r_d.dout = r_d.sr[SHIFT_W-1];  // see RULE21

    // watchdog, live only in user mode of a remote application image
    wd_run = (r_q.st == RSU_USER) && r_q.remote && app_img &&
             r_q.ctrl[WDEN_BIT];  // see RULE8
    if (wd_run) begin
      if (pin_fall[5]) begin
        r_d.wd = wd_load(r_q.ctrl);  // see RULE10, RULE12
      end else if (r_q.osc == '0) begin
        if (r_q.wd == '0) begin
          cause[ST_WDOG] = 1'b1;  // see RULE11
        end else begin
          r_d.wd = r_q.wd - 1'b1;  // see RULE7
        end
      end
    end

    // trigger sources
    if (pin_fall[6]) begin
      cause[ST_STATUS] = 1'b1;
    end
    if (pin_rise[4] && r_q.st == RSU_USER) begin
      cause[ST_FABRIC] = 1'b1;  // see RULE14
    end

    // register writes
    if (wr_go && r_q.wen) begin
      unique case (r_q.awaddr)
        OFS_MODE: begin
          r_d.remote = r_q.wdata[0];
          r_d.ctrl   = r_q.wdata[0] ? CTRL_RST_REMOTE : CTRL_LOCAL_APP;  // see RULE25
          r_d.stat   = STAT_RST;  // see RULE24
          r_d.st     = RSU_CONFIG;
        end
        OFS_CMD: begin
          if (r_q.wdata[CMD_CFG_DONE] && r_q.st == RSU_CONFIG) begin
            r_d.st = RSU_USER;
            r_d.wd = wd_load(r_q.ctrl);  // see RULE8
          end
          cause[ST_CHECKSUM] = r_q.wdata[CMD_CHECKSUM];
          cause[ST_EXTRST]   = r_q.wdata[CMD_EXTRST];
        end
        default: begin
        end
      endcase
    end

    // a trigger records its cause and restarts configuration
    if (cause != '0) begin
      r_d.stat   = cause;  // see RULE5
      r_d.ctrl   = next_ctrl(cause, r_q.remote, r_q.ctrl, r_q.upd);
      r_d.st     = RSU_CONFIG;  // see RULE8
      r_d.wd     = '0;
      r_d.reconf = 1'b1;
    end
  end

  // ==========================================================
  // register the state; control and status start as in remote mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_q        <= '0;
      r_q.remote <= REMOTE_RST;
      r_q.st     <= RSU_CONFIG;
      r_q.ctrl   <= CTRL_RST_REMOTE;  // see RULE25
      r_q.stat   <= STAT_RST;  // see RULE24
      r_q.awrdy  <= 1'b1;
      r_q.wrdy   <= 1'b1;
      r_q.arrdy  <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  // ==========================================================
  // outputs, all straight from flops
  assign s_axi_awready      = r_q.awrdy;
  assign s_axi_wready       = r_q.wrdy;
  assign s_axi_bvalid       = r_q.bvalid;
  assign s_axi_bresp        = r_q.bresp;
  assign s_axi_arready      = r_q.arrdy;
  assign s_axi_rvalid       = r_q.rvalid;
  assign s_axi_rdata        = r_q.rdata;
  assign s_axi_rresp        = r_q.rresp;
  assign upgrade_serial_out = r_q.dout;
  assign reconfig_start     = r_q.reconf;

endmodule

// *** tb/rsu_ctrl_checker.sv ***
// port assertions for the remote upgrade controller
// assumes it is bound onto rsu_ctrl; everything runs on aclk
`timescale 1ns/1ns
module rsu_ctrl_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        upgrade_shift_clock,
  input wire logic        upgrade_serial_out,
  input wire logic        external_status_error_n,
  input wire logic        reconfig_start
);
  // ==========
  // cycles since the shift clock pin last moved, saturating
  logic [3:0] quiet_q;
  logic       sclk_q;
  always_ff @(posedge aclk) begin
    sclk_q <= upgrade_shift_clock;
    if (!aresetn || upgrade_shift_clock != sclk_q) quiet_q <= 4'h0;
    else if (quiet_q != 4'hf) quiet_q <= quiet_q + 4'h1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========
  // bus handshakes, reconfiguration start and shift port timing
  write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  read_resp_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read not answered");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  status_trig_a: assert property ($fell(external_status_error_n) |-> ##[2:6] reconfig_start)
    else $error("status error ignored");
  start_pulse_a: assert property (reconfig_start |=> !reconfig_start)
    else $error("start longer than one cycle");
  dout_quiet_a: assert property (quiet_q > 4'h7 |-> $stable(upgrade_serial_out))
    else $error("serial out moved without shift clock");
endmodule
bind rsu_ctrl rsu_ctrl_checker rsu_ctrl_checker_i (.*);

// *** tb/rsu_user_model.sv ***
// model of the fabric user logic that drives the upgrade shift port
// assumes the pins are sampled by aclk; shift clock stands low between frames
`timescale 1ns/1ns
module rsu_user_model (
  output logic      upgrade_shift_clock,
  output logic      shift_not_load_select,
  output logic      capture_not_update_select,
  output logic      upgrade_serial_in,
  output logic      fabric_reconfig_request_n,
  output logic      watchdog_restart_n,
  input  wire logic upgrade_serial_out
);
  // ==========
  // idle levels: clock still, shift selected, requests released
  initial begin
    upgrade_shift_clock = 1'b0;
    shift_not_load_select = 1'b1;
    capture_not_update_select = 1'b1;
    upgrade_serial_in = 1'b0;
    fabric_reconfig_request_n = 1'b1;
    watchdog_restart_n = 1'b1;
  end
  // one 80 ns shift clock period, output read just before the fall
  task automatic step(output logic b);
    #40 upgrade_shift_clock = 1'b1;
    #40 b = upgrade_serial_out;
    upgrade_shift_clock = 1'b0;
  endtask
  // shift a word in msb first, then copy it into the update register
  task automatic load_update(input logic [20:0] v);
    logic b;
    #7;
    for (int i = 20; i >= 0; i--) begin
      upgrade_serial_in = v[i];
      step(b);
    end
    shift_not_load_select = 1'b0;
    capture_not_update_select = 1'b0;
    step(b);
    shift_not_load_select = 1'b1;
    capture_not_update_select = 1'b1;
    upgrade_serial_in = ~upgrade_serial_in; // released line shows the inverse
  endtask
  // capture status and register, then shift all 26 bits out
  task automatic capture(output logic [25:0] v);
    logic b;
    #7;
    shift_not_load_select = 1'b0;
    step(b);
    v[25] = b;
    shift_not_load_select = 1'b1;
    for (int i = 24; i >= 0; i--) begin
      step(b);
      v[i] = b;
    end
  endtask
  // request a reconfiguration, released after 80 ns
  task automatic pulse_fabric();
    #7 fabric_reconfig_request_n = 1'b0;
    #80 fabric_reconfig_request_n = 1'b1;
  endtask
  // restart the watchdog with a falling edge
  task automatic pulse_restart();
    #7 watchdog_restart_n = 1'b0;
    #80 watchdog_restart_n = 1'b1;
  endtask
endmodule

// *** tb/rsu_ctrl_bench.sv ***
// self-checking bench for the remote upgrade controller
// assumes rsu_ctrl, the user logic model and the bound checker
`timescale 1ns/1ns
module rsu_ctrl_bench;
  import rsu_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, external_status_error_n, reconfig_start;
  logic        upgrade_shift_clock, shift_not_load_select, capture_not_update_select;
  logic        upgrade_serial_in, upgrade_serial_out, fabric_reconfig_request_n;
  logic        watchdog_restart_n;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, w1, w2, w3;
  logic [25:0] v;
  int          failures = 0;
  int          n_checks = 0;
  rsu_ctrl rsu_ctrl_i (.*);
  rsu_user_model rsu_user_model_i (.*);
  always #2 aclk = ~aclk;
  // ==========
  // verdict, comparison and bounded wait
  task automatic results();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic bound(inout int n);
    n++;
    if (n > 300) begin
      failures++;
      $display("mismatch at %0t: wait ran out", $time);
      results();
    end
  endtask
  // ==========
  // bus cycles: valid held until taken, ready held until answered
  task automatic axw(input logic [7:0] a, input logic [31:0] x, input logic [1:0] er);
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= x;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      bound(n);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er), "bresp");
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] x, input logic [1:0] er);
    int n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      bound(n);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    x = s_axi_rdata;
    chk(32'(s_axi_rresp), 32'(er), "rresp");
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string what);
    logic [31:0] x;
    axr(a, x, RESP_OKAY);
    chk(x, e, what);
  endtask
  task automatic wait_rs();
    int n = 0;
    do begin
      @(posedge aclk);
      bound(n);
    end while (reconfig_start !== 1'b1);
  endtask
  // factory image programs the update register, then asks for the application
  task automatic to_app(input logic [20:0] u);
    axw(OFS_CMD, 32'h1, RESP_OKAY);
    rsu_user_model_i.load_update(u);
    fork
      rsu_user_model_i.pulse_fabric();
      wait_rs();
    join
  endtask
  // ==========
  // main sequence
  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h00000;
    {s_axi_awprot, s_axi_arprot, s_axi_wdata} = 38'h0;
    s_axi_wstrb = 4'hf;
    external_status_error_n = 1'b1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    rdc(OFS_MODE, 32'h1, "mode");
    rdc(OFS_CONTROL, 32'h0, "control reset");
    rdc(OFS_STATUS, 32'h0, "status reset");
    axr(8'h18, d, RESP_SLVERR);
    axw(8'h18, 32'h0, RESP_SLVERR);
    rsu_user_model_i.load_update(21'h00000b);
    rdc(OFS_UPDATE, 32'h0b, "update written");
    rsu_user_model_i.capture(v);
    chk(32'(v), 32'h0b, "capture factory");
    to_app(21'h00000b);
    rdc(OFS_CONTROL, 32'h0b, "control from update");
    rdc(OFS_STATUS, 32'h04, "fabric cause");
    axw(OFS_CMD, 32'h1, RESP_OKAY);
    rsu_user_model_i.load_update(21'h1ffffe);
    rdc(OFS_UPDATE, 32'h0b, "update locked in app");
    rsu_user_model_i.capture(v);
    chk(32'(v), 32'h0080000b, "capture app");
    fork
      rsu_user_model_i.pulse_fabric();
      wait_rs();
    join
    rdc(OFS_CONTROL, 32'h0, "app to factory");
    to_app(21'h00030b);
    axw(OFS_CMD, 32'h1, RESP_OKAY);
    axr(OFS_WDOG, w1, RESP_OKAY);
    chk(32'(w1 <= 32'h20000 && w1 > 32'h1fff0), 32'h1, "wdog load");
    repeat (500) @(posedge aclk);
    axr(OFS_WDOG, w2, RESP_OKAY);
    chk(32'(w1 - w2 >= 19 && w1 - w2 <= 21), 32'h1, "wdog rate");
    rsu_user_model_i.pulse_restart();
    repeat (10) @(posedge aclk);
    axr(OFS_WDOG, w3, RESP_OKAY);
    chk(32'(w3 > w2 + 32'h8), 32'h1, "wdog reload");
    axw(OFS_CMD, 32'h4, RESP_OKAY);
    rdc(OFS_CONTROL, 32'h0, "ext reset remote");
    rdc(OFS_STATUS, 32'h08, "ext reset cause");
    to_app(21'h00010b);
    fork
      axw(OFS_CMD, 32'h1, RESP_OKAY);
      wait_rs();
    join
    rdc(OFS_STATUS, 32'h10, "watchdog cause");
    rdc(OFS_CONTROL, 32'h0, "watchdog fallback");
    external_status_error_n <= 1'b0;
    wait_rs();
    external_status_error_n <= 1'b1;
    rdc(OFS_STATUS, 32'h02, "status error cause");
    axw(OFS_CMD, 32'h2, RESP_OKAY);
    rdc(OFS_STATUS, 32'h01, "checksum cause");
    rdc(OFS_CONTROL, 32'h0, "checksum fallback");
    axw(OFS_MODE, 32'h0, RESP_OKAY);
    rdc(OFS_CONTROL, 32'h3, "local power-up");
    rsu_user_model_i.load_update(21'h1ffffe);
    rdc(OFS_UPDATE, 32'h10b, "local update locked");
    axw(OFS_CMD, 32'h4, RESP_OKAY);
    rdc(OFS_CONTROL, 32'h3, "local ext reset");
    axw(OFS_CMD, 32'h1, RESP_OKAY);
    fork
      rsu_user_model_i.pulse_fabric();
      wait_rs();
    join
    rdc(OFS_CONTROL, 32'h3, "local fabric");
    rdc(OFS_STATUS, 32'h04, "local fabric cause");
    results();
  end
endmodule
